// ---- core/ahsps_host.sv ----
// host-side controller that drives the two-channel converter's serial link
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - converter clock is the inverted transmit clock; idle-high output already includes it.
// - frames run in bursts on an internal clock; frame signal acts as chip-select.
// - framing and clock are generated internally, frame format cleared.
// - active-low frame per word, right-justified 16-bit words, internal clock.
// - the one transmit frame also times the readback of the result.
// - each sample trigger accepted while idle sends one control word inside one frame; a trigger while busy is lost.
// - a requested frame waits for the serial clock phase boundary before starting.
// - periodic sample triggers are spaced by a whole number of serial clock periods; a start strobe can land on any cycle.
// - one shared frame, internally generated, sixteen-bit words.
// - master with clock idle high and data sampled on the rising edge.
// - byte mode makes two 8-bit transfers, two half periods apart, with chip-select held.
// - clock, data out and data in are three plain pins, full duplex.
// - chip-select is a separate output, clock polarity idle high.
// - every frame carries exactly sixteen clocks inside one chip-select low period.
// - the control byte is shifted out first, during the first eight clocks.
module ahsps_host #(
  parameter int SCLK_HALF = ahsps_pkg::SCLK_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out,
  input wire logic dout_in
);

  // the synchroniser costs two cycles, so a half period must exceed that
  initial begin
    if (SCLK_HALF < 3 || SCLK_HALF > 255) begin
      $error("SCLK_HALF must lie between 3 and 255");
    end
  end

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
  localparam logic [4:0] BITS_ALL = 5'(ahsps_pkg::FRAME_BITS);
  localparam logic [4:0] BITS_BYTE = 5'(ahsps_pkg::CTRL_BITS);
  localparam logic [1:0] GAP_LAST = 2'(ahsps_pkg::BYTE_GAP_HALVES - 1);

  // package figures the frame engine leans upon; a bad value would silently
  // shorten a frame or let the byte pause counter wrap
  initial begin
    if (ahsps_pkg::FRAME_BITS < 1 || ahsps_pkg::FRAME_BITS > 16) begin
      $error("frame length must lie between 1 and 16 bits");
    end
    if (ahsps_pkg::CTRL_BITS < 1 || ahsps_pkg::CTRL_BITS >= ahsps_pkg::FRAME_BITS) begin
      $error("control byte must be shorter than the frame");
    end
    if (2 * ahsps_pkg::CTRL_BITS != ahsps_pkg::FRAME_BITS) begin
      $error("byte mode needs a frame of two equal transfers");
    end
    if (ahsps_pkg::BYTE_GAP_HALVES < 1 || ahsps_pkg::BYTE_GAP_HALVES > 4) begin
      $error("byte pause must lie between 1 and 4 half periods");
    end
    if (ahsps_pkg::INTERVAL_RESET == 16'h0000) begin
      $error("reset interval must be nonzero");
    end
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_GAP,
    ST_LAST
  } ahsps_state_t;

  typedef struct packed {
    // frame engine
    ahsps_state_t st;
    // half-period timebase
    logic [7:0] hcnt;
    logic phase;
    // sample timer, pending trigger, link pins and shift registers
    logic [15:0] tmr;
    logic pend;
    logic sclk;
    logic cs_n;
    logic din;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [4:0] bits;
    logic [1:0] gap;
    // results and flags
    logic [15:0] result;
    logic valid;
    logic ovr;
    // software registers
    logic per_en;
    logic byte_mode;
    logic [7:0] cmd;
    logic [15:0] interval;
    logic [15:0] rdata;
    // two-flop synchroniser for converter data
    logic sync1;
    logic sync2;
  } ahsps_regs_t;

  ahsps_regs_t s_r;
  ahsps_regs_t s_nxt;

  // a frame owed or under way: shown as busy, and the reason a new trigger is refused
  function automatic logic frame_busy(input ahsps_regs_t s);
    logic b;
    b = s.pend || (s.st != ST_IDLE);
    return b;
  endfunction

  // the control byte leads the word; the trailing bits stay zero so the
  // converter's control register only sees the first eight
  function automatic logic [15:0] frame_word(input logic [7:0] c);
    logic [15:0] w;
    w = 16'h0000;
    w[15:8] = c;
    return w;
  endfunction

  // byte-wide hosts pause after the control byte; full-width hosts run straight through
  function automatic logic pause_here(input logic byte_mode, input logic [4:0] n);
    logic p;
    p = byte_mode && (n == BITS_BYTE);
    return p;
  endfunction

  function automatic logic frame_done(input logic [4:0] n);
    logic d;
    d = (n == BITS_ALL);
    return d;
  endfunction

  function automatic logic [15:0] ctrl_word(input ahsps_regs_t s);
    logic [15:0] v;
    v = 16'h0000;
    // start is a strobe, so it always reads back as zero
    v[ahsps_pkg::CTRL_PERIODIC_BIT] = s.per_en;
    v[ahsps_pkg::CTRL_BYTE_MODE_BIT] = s.byte_mode;
    return v;
  endfunction

  function automatic logic [15:0] status_word(input ahsps_regs_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[ahsps_pkg::STAT_BUSY_BIT] = frame_busy(s);
    v[ahsps_pkg::STAT_VALID_BIT] = s.valid;
    v[ahsps_pkg::STAT_OVERRUN_BIT] = s.ovr;
    return v;
  endfunction

  function automatic logic [15:0] read_mux(input ahsps_regs_t s, input logic [3:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      ahsps_pkg::ADDR_CTRL: begin
        v = ctrl_word(s);
      end
      ahsps_pkg::ADDR_CMD: begin
        v = {8'h00, s.cmd};
      end
      ahsps_pkg::ADDR_INTERVAL: begin
        v = s.interval;
      end
      ahsps_pkg::ADDR_STATUS: begin
        v = status_word(s);
      end
      ahsps_pkg::ADDR_RESULT: begin
        v = s.result;
      end
      // unmapped indices read as zero rather than echoing a neighbour
      default: begin
        v = 16'h0000;
      end
    endcase
    return v;
  endfunction

  always_comb begin
    logic tick;
    logic period_end;
    logic trig;
    logic [4:0] bits_inc;
    tick = 1'b0;
    period_end = 1'b0;
    trig = 1'b0;
    bits_inc = 5'h00;
    s_nxt = s_r;

    // converter data out is asynchronous to this clock
    // a half period no longer than the two-flop delay would capture the previous bit
    s_nxt.sync1 = dout_in;
    s_nxt.sync2 = s_r.sync1;

    // free-running half-period timebase; frames start only on its boundary
    tick = (s_r.hcnt == HALF_LAST);
    if (tick) begin
      s_nxt.hcnt = 8'h00;
    end else begin
      s_nxt.hcnt = s_r.hcnt + 8'h01;
    end
    if (tick) begin
      s_nxt.phase = ~s_r.phase;
    end
    period_end = tick && s_r.phase;

    // sample timer counts whole serial clock periods, so spacing never jitters
    // an interval of zero behaves as one
    if (!s_r.per_en) begin
      s_nxt.tmr = 16'h0000;
    end else if (period_end) begin
      if (({1'b0, s_r.tmr} + 17'h00001) >= {1'b0, s_r.interval}) begin
        s_nxt.tmr = 16'h0000;
        trig = 1'b1;
      end else begin
        s_nxt.tmr = s_r.tmr + 16'h0001;
      end
    end

    // command port
    // rdata is zero outside its answer cycle, so a stale word never looks like a fresh read
    if (rd) begin
      s_nxt.rdata = read_mux(s_r, addr);
    end else begin
      s_nxt.rdata = 16'h0000;
    end
    // taking the result hands it over, so valid drops
    if (rd && addr == ahsps_pkg::ADDR_RESULT) begin
      s_nxt.valid = 1'b0;
    end
    if (wr) begin
      unique case (addr)
        ahsps_pkg::ADDR_CTRL: begin
          s_nxt.per_en = wdata[ahsps_pkg::CTRL_PERIODIC_BIT];
          s_nxt.byte_mode = wdata[ahsps_pkg::CTRL_BYTE_MODE_BIT];
          if (wdata[ahsps_pkg::CTRL_START_BIT]) begin
            trig = 1'b1;
          end
        end
        ahsps_pkg::ADDR_CMD: begin
          s_nxt.cmd = wdata[7:0];
        end
        ahsps_pkg::ADDR_INTERVAL: begin
          s_nxt.interval = wdata;
        end
        // overrun is write-one-to-clear, so writing zeros leaves it alone
        ahsps_pkg::ADDR_STATUS: begin
          if (wdata[ahsps_pkg::STAT_OVERRUN_BIT]) begin
            s_nxt.ovr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // a trigger while a frame is pending or running is lost and flagged
    if (trig) begin
      if (frame_busy(s_r)) begin
        s_nxt.ovr = 1'b1;
      end else begin
        s_nxt.pend = 1'b1;
      end
    end

    // frame engine: clock idles high, falling edge drives, rising edge samples
    unique case (s_r.st)
      ST_IDLE: begin
        // clock parked high between frames so the converter sees no stray edge
        s_nxt.sclk = 1'b1;
        s_nxt.cs_n = 1'b1;
        if (tick && s_r.pend) begin
          // one trigger, one frame, one control word; the same frame reads back
          s_nxt.pend = 1'b0;
          s_nxt.cs_n = 1'b0;
          s_nxt.tx = frame_word(s_r.cmd);
          s_nxt.din = s_r.cmd[7];
          s_nxt.bits = 5'h00;
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tick) begin
          if (s_r.sclk) begin
            // control byte goes out first, msb first
            s_nxt.sclk = 1'b0;
            s_nxt.din = s_r.tx[15];
            s_nxt.tx = {s_r.tx[14:0], 1'b0};
          end else begin
            bits_inc = s_r.bits + 5'h01;
            s_nxt.sclk = 1'b1;
            s_nxt.rx = {s_r.rx[14:0], s_r.sync2};
            s_nxt.bits = bits_inc;
            if (frame_done(bits_inc)) begin
              s_nxt.st = ST_LAST;
            end else if (pause_here(s_r.byte_mode, bits_inc)) begin
              // byte-wide host: two transfers, chip-select held between them
              s_nxt.gap = 2'h0;
              s_nxt.st = ST_GAP;
            end
          end
        end
      end
      ST_GAP: begin
        // clock holds high while chip-select stays low between the two bytes
        if (tick) begin
          if (s_r.gap == GAP_LAST) begin
            s_nxt.st = ST_RUN;
          end else begin
            s_nxt.gap = s_r.gap + 2'h1;
          end
        end
      end
      ST_LAST: begin
        // release half a period after the final capture
        if (tick) begin
          s_nxt.cs_n = 1'b1;
          s_nxt.din = 1'b0;
          s_nxt.result = s_r.rx;
          s_nxt.valid = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r <= '{
        st: ST_IDLE,
        hcnt: 8'h00,
        phase: 1'b0,
        tmr: 16'h0000,
        pend: 1'b0,
        sclk: 1'b1,
        cs_n: 1'b1,
        din: 1'b0,
        tx: 16'h0000,
        rx: 16'h0000,
        bits: 5'h00,
        gap: 2'h0,
        result: 16'h0000,
        valid: 1'b0,
        ovr: 1'b0,
        per_en: 1'b0,
        byte_mode: 1'b0,
        cmd: ahsps_pkg::CMD_RESET,
        interval: ahsps_pkg::INTERVAL_RESET,
        rdata: 16'h0000,
        sync1: 1'b0,
        sync2: 1'b0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // clock leaves already in the polarity the converter wants; no inverter outside
  // three plain pins plus chip-select give full duplex
  // every link pin comes straight from a flop, so no glitch reaches the converter
  assign sclk_out = s_r.sclk;
  assign cs_n_out = s_r.cs_n;
  assign din_out = s_r.din;
  assign rdata = s_r.rdata;

endmodule

`default_nettype wire

// ---- core/ahsps_pkg.sv ----
// constants for the converter serial link controller (host end)
package ahsps_pkg;
  // register indices on the command port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_INTERVAL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_RESULT = 4'h4;
  // control register fields
  localparam int CTRL_PERIODIC_BIT = 0;
  localparam int CTRL_BYTE_MODE_BIT = 1;
  localparam int CTRL_START_BIT = 2;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_OVERRUN_BIT = 2;
  // values after reset
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [15:0] INTERVAL_RESET = 16'h0040;
  // frame shape
  localparam int FRAME_BITS = 16;
  localparam int CTRL_BITS = 8;
  // clock figures
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCLK_HALF_NS = 300;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // byte-mode pause between the two bytes, in half periods of the serial clock
  localparam int BYTE_GAP_HALVES = 2;
endpackage

// ---- verification/ahsps_adc_model.sv ----
// behavioural converter at the far end of the serial link
`timescale 1ns/1ns
`default_nettype none
module ahsps_adc_model #(
  parameter logic [15:0] WORD = 16'h0b6d
) (
  input wire logic sclk_out,
  input wire logic cs_n_out,
  input wire logic din_out,
  output logic dout_in,
  output logic [7:0] ctrl_byte
);
  int n = 0;
  initial dout_in = 1'b0;
  initial ctrl_byte = 8'h00;
  always @(negedge cs_n_out) n = 0;
  // a released line flips its last bit, so a stale value never passes for data
  always @(posedge cs_n_out) dout_in = ~dout_in;
  always @(negedge sclk_out) if (!cs_n_out) dout_in = WORD[15 - n];
  always @(posedge sclk_out) if (!cs_n_out) begin
    if (n < 8) ctrl_byte = {ctrl_byte[6:0], din_out};
    n = n + 1;
  end
endmodule
`default_nettype wire

// ---- verification/ahsps_host_props.sv ----
// link assertions for the converter host controller
`timescale 1ns/1ns
`default_nettype none
module ahsps_host_props (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic sclk_out,
  input wire logic cs_n_out,
  input wire logic din_out
);
  logic [4:0] cnt_r;
  logic byte_r, sq_r;
  wire logic rise = sclk_out & ~sq_r;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r <= 5'h00;
      byte_r <= 1'b0;
      sq_r <= 1'b1;
    end else begin
      sq_r <= sclk_out;
      cnt_r <= cs_n_out ? 5'h00 : cnt_r + 5'(rise);
      if (wr && addr == ahsps_pkg::ADDR_CTRL) byte_r <= wdata[ahsps_pkg::CTRL_BYTE_MODE_BIT];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_idle_clock_high: assert property (cs_n_out |-> sclk_out)
    else $error("clock low while idle");
  a_start_timing: assert property ($fell(cs_n_out) |-> sclk_out [*3] ##1 !sclk_out)
    else $error("first clock fall misplaced");
  a_din_on_fall: assert property (!cs_n_out && !$fell(cs_n_out) && $changed(din_out)
    |-> $fell(sclk_out)) else $error("data moved off a falling clock");
  a_sixteen_clocks: assert property ($rose(cs_n_out) |-> cnt_r == 5'h10)
    else $error("frame clock count wrong");
  a_hold_after_last: assert property (
    rise && cnt_r == 5'h0f |-> !cs_n_out [*3] ##1 cs_n_out) else $error("select release");
  a_select_gap: assert property ($rose(cs_n_out) |-> cs_n_out [*3])
    else $error("select high too briefly");
  a_high_phase: assert property (
    rise && cnt_r < 5'h0f && !(byte_r && cnt_r == 5'h07) |-> sclk_out [*3] ##1 !sclk_out)
    else $error("high phase length");
  a_byte_pause: assert property (
    rise && byte_r && cnt_r == 5'h07 |-> sclk_out [*8] ##1 sclk_out ##1 !sclk_out)
    else $error("byte pause length");
  cover property ($rose(cs_n_out));
  cover property (rise && byte_r && cnt_r == 5'h07);
  cover property ($fell(cs_n_out) && !byte_r);
endmodule
bind ahsps_host ahsps_host_props u_props (.clock, .reset, .addr, .wdata, .wr, .sclk_out,
  .cs_n_out, .din_out);
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the converter host controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [15:0] WORD = 16'h0b6d;
  logic clock = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, v;
  wire logic [15:0] rdata;
  wire logic sclk_out, cs_n_out, din_out, dout_in;
  wire logic [7:0] ctrl_byte;
  int num_errors = 0, compares = 0;
  time t0 = 0, t1 = 0;
  ahsps_host dut (.clock, .reset, .addr, .wdata, .wr, .rd, .rdata, .sclk_out, .cs_n_out,
    .din_out, .dout_in);
  ahsps_adc_model #(.WORD(WORD)) adc (.sclk_out, .cs_n_out, .din_out, .dout_in, .ctrl_byte);
  initial forever #50 clock = ~clock;
  always @(negedge cs_n_out) begin
    t0 = t1;
    t1 = $time;
  end
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic reset_state;
    bus(1'b0, ahsps_pkg::ADDR_INTERVAL, 16'h0000);
    check("interval", v, ahsps_pkg::INTERVAL_RESET);
    bus(1'b0, 4'h9, 16'h0000);
    check("unmapped", v, 16'h0000);
  endtask
  task automatic one_frame(input logic [7:0] cmd, input logic b);
    bus(1'b1, ahsps_pkg::ADDR_CMD, {8'h00, cmd});
    bus(1'b1, ahsps_pkg::ADDR_CTRL,
      16'((1 << ahsps_pkg::CTRL_START_BIT) | (b << ahsps_pkg::CTRL_BYTE_MODE_BIT)));
    // start lands within one tick and a frame runs at most 35 ticks
    repeat (112) @(posedge clock);
    bus(1'b0, ahsps_pkg::ADDR_STATUS, 16'h0000);
    check("status", v, 16'h0001 << ahsps_pkg::STAT_VALID_BIT);
    bus(1'b0, ahsps_pkg::ADDR_RESULT, 16'h0000);
    check("result", v, WORD);
    check("control byte", {8'h00, ctrl_byte}, {8'h00, cmd});
  endtask
  task automatic overrun;
    bus(1'b1, ahsps_pkg::ADDR_CTRL, 16'h0001 << ahsps_pkg::CTRL_START_BIT);
    bus(1'b1, ahsps_pkg::ADDR_CTRL, 16'h0001 << ahsps_pkg::CTRL_START_BIT);
    bus(1'b0, ahsps_pkg::ADDR_STATUS, 16'h0000);
    check("status busy", v, (16'h0001 << ahsps_pkg::STAT_BUSY_BIT) |
      (16'h0001 << ahsps_pkg::STAT_OVERRUN_BIT));
    repeat (112) @(posedge clock);
    bus(1'b0, ahsps_pkg::ADDR_RESULT, 16'h0000);
    check("result again", v, WORD);
    bus(1'b1, ahsps_pkg::ADDR_STATUS, 16'h0001 << ahsps_pkg::STAT_OVERRUN_BIT);
    bus(1'b0, ahsps_pkg::ADDR_STATUS, 16'h0000);
    check("status clear", v, 16'h0000);
  endtask
  task automatic periodic;
    bus(1'b1, ahsps_pkg::ADDR_INTERVAL, 16'h0014);
    bus(1'b1, ahsps_pkg::ADDR_CTRL, 16'h0001 << ahsps_pkg::CTRL_PERIODIC_BIT);
    repeat (400) @(posedge clock);
    check("spacing", 16'((t1 - t0) / 100), 16'(40 * ahsps_pkg::SCLK_HALF_CYCLES));
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    reset_state;
    one_frame(8'ha5, 1'b0);
    one_frame(8'h3c, 1'b1);
    overrun;
    periodic;
    wrap_up;
  end
endmodule
`default_nettype wire
